// ### logic/fsef_pkg.sv
// shared constants and types for the fault status event filter
package fsef_pkg;

    // ==================================================================
    // field layout of the fault status word
    localparam int FSEF_WIDTH = 9;
    localparam int FSEF_BUS_WIDTH = 16;
    localparam int BIT_OVERVOLTAGE = 8;
    localparam int BIT_LINE_INPUT = 7;
    localparam int BIT_OVERCURRENT = 6;
    localparam int BIT_COOLING = 5;
    localparam int BIT_OUTPUT_SHORT = 4;
    localparam int BIT_OVERTEMP = 3;
    localparam int BIT_OVERPOWER = 2;

    // ==================================================================
    // values after reset
    localparam logic [FSEF_WIDTH-1:0] FIELD_RESET = 9'h000;
    localparam logic [FSEF_BUS_WIDTH-1:0] WORD_RESET = 16'h0000;

    // ==================================================================
    // register selector of the command port
    typedef enum logic [2:0] {
        SEL_CONDITION = 3'h0,
        SEL_EVENT = 3'h1,
        SEL_EVENT_MASK = 3'h3,
        SEL_FALL_EDGE = 3'h2,
        SEL_RISE_EDGE = 3'h6
    } fsef_sel_t;

endpackage

// ### logic/fsef_evt_if.sv
// carrier between the register front end and the edge filter
`timescale 1ns/100ps
interface fsef_evt_if;
    logic [fsef_pkg::FSEF_WIDTH-1:0] cond;
    logic [fsef_pkg::FSEF_WIDTH-1:0] fall_sel;
    logic [fsef_pkg::FSEF_WIDTH-1:0] rise_sel;
    logic [fsef_pkg::FSEF_WIDTH-1:0] event_q;
    logic clear;

    modport filt (
        input cond,
        input fall_sel,
        input rise_sel,
        input clear,
        output event_q
    );

    modport ctrl (
        output cond,
        output fall_sel,
        output rise_sel,
        output clear,
        input event_q
    );
endinterface

// ### logic/fsef_edge_filter.sv
// per-bit transition filter and sticky event latch
`timescale 1ns/100ps
module fsef_edge_filter (
    input wire logic clk,
    input wire logic rst_n,
    fsef_evt_if.filt evt
);
    import fsef_pkg::*;

    logic [FSEF_WIDTH-1:0] prev_reg;
    logic [FSEF_WIDTH-1:0] prev_next;
    logic [FSEF_WIDTH-1:0] event_reg;
    logic [FSEF_WIDTH-1:0] event_next;
    logic [FSEF_WIDTH-1:0] set_vec;

    // ==================================================================
    // transition detection
    for (genvar i = 0; i < FSEF_WIDTH; i++) begin : g_bit
        assign set_vec[i] = (evt.fall_sel[i] & prev_reg[i] & ~evt.cond[i])
                          | (evt.rise_sel[i] & ~prev_reg[i] & evt.cond[i]);

        fall_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
            (evt.fall_sel[i] && prev_reg[i] && !evt.cond[i]) |=> event_reg[i])
            else $error("falling edge did not latch its event");
        rise_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
            (evt.rise_sel[i] && !prev_reg[i] && evt.cond[i]) |=> event_reg[i])
            else $error("rising edge did not latch its event");
        no_select_a: assert property (@(posedge clk) disable iff (!rst_n)
            (!evt.fall_sel[i] && !evt.rise_sel[i] && !event_reg[i]) |=> !event_reg[i])
            else $error("event set with both edge selects off");
        event_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
            (event_reg[i] && !evt.clear) |=> event_reg[i])
            else $error("latched event dropped without a read");
        read_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
            (evt.clear && !set_vec[i]) |=> !event_reg[i])
            else $error("event survived its read");
    end

    // ==================================================================
    // event latch; a new edge in the read cycle wins over the clear
    always_comb begin
        prev_next = evt.cond;
        event_next = (event_reg & ~{FSEF_WIDTH{evt.clear}}) | set_vec;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= FIELD_RESET;
            event_reg <= FIELD_RESET;
        end else begin
            prev_reg <= prev_next;
            event_reg <= event_next;
        end
    end

    assign evt.event_q = event_reg;

endmodule

// ### logic/fsef_fault_status.sv
// fault status registers: condition, edge selects, event latch, summary bit
`timescale 1ns/100ps

module fsef_fault_status (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic OVERVOLTAGE_FAULT,
    input wire logic LINE_INPUT_FAULT,
    input wire logic OVERCURRENT_FAULT,
    input wire logic COOLING_FAULT,
    input wire logic OUTPUT_SHORT_FAULT,
    input wire logic OVERTEMP_FAULT,
    input wire logic OVERPOWER_FAULT,
    input wire logic SRQ_FAULT_ENABLE,
    input wire logic CMD_WRITE,
    input wire logic CMD_READ,
    input wire fsef_pkg::fsef_sel_t CMD_SEL,
    input wire logic [fsef_pkg::FSEF_BUS_WIDTH-1:0] CMD_WDATA,
    output logic [fsef_pkg::FSEF_BUS_WIDTH-1:0] RDATA,
    output logic RDATA_VALID,
    output logic FAULT_SUMMARY_BIT
);
    import fsef_pkg::*;

    fsef_evt_if evt ();

    logic [FSEF_WIDTH-1:0] cond_in;
    logic [FSEF_WIDTH-1:0] cond_reg;
    logic [FSEF_WIDTH-1:0] cond_next;
    logic [FSEF_WIDTH-1:0] mask_reg;
    logic [FSEF_WIDTH-1:0] mask_next;
    logic [FSEF_WIDTH-1:0] fall_reg;
    logic [FSEF_WIDTH-1:0] fall_next;
    logic [FSEF_WIDTH-1:0] rise_reg;
    logic [FSEF_WIDTH-1:0] rise_next;
    logic [FSEF_BUS_WIDTH-1:0] rdata_reg;
    logic [FSEF_BUS_WIDTH-1:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic summary_reg;
    logic summary_next;

    // ==================================================================
    // decode helpers
    function automatic logic write_to(input fsef_sel_t sel);
        write_to = CMD_WRITE && (CMD_SEL == sel);
    endfunction

    // nine-bit field widened to the bus word, upper bits reading zero
    function automatic logic [FSEF_BUS_WIDTH-1:0] widen(input logic [FSEF_WIDTH-1:0] f);
        widen = {{(FSEF_BUS_WIDTH - FSEF_WIDTH){1'b0}}, f};
    endfunction

    // ==================================================================
    // live fault conditions
    // one register stage gives the filter and the read port the same view
    always_comb begin
        cond_in = FIELD_RESET;
        cond_in[BIT_OVERVOLTAGE] = OVERVOLTAGE_FAULT;
        cond_in[BIT_LINE_INPUT] = LINE_INPUT_FAULT;
        cond_in[BIT_OVERCURRENT] = OVERCURRENT_FAULT;
        cond_in[BIT_COOLING] = COOLING_FAULT;
        cond_in[BIT_OUTPUT_SHORT] = OUTPUT_SHORT_FAULT;
        cond_in[BIT_OVERTEMP] = OVERTEMP_FAULT;
        cond_in[BIT_OVERPOWER] = OVERPOWER_FAULT;
        cond_next = cond_in;
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cond_reg <= FIELD_RESET;
        end else begin
            cond_reg <= cond_next;
        end
    end

    cond_live_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        ##1 (cond_reg == $past(cond_in)))
        else $error("condition register does not follow the fault inputs");
    cond_layout_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        OVERVOLTAGE_FAULT |=> (cond_reg[8] && cond_reg[1:0] == 2'h0))
        else $error("overvoltage not at bit 8 or low bits not zero");

    // ==================================================================
    // writable select and mask registers; only nine bits are kept
    always_comb begin
        mask_next = mask_reg;
        fall_next = fall_reg;
        rise_next = rise_reg;
        if (write_to(SEL_EVENT_MASK)) begin
            mask_next = CMD_WDATA[FSEF_WIDTH-1:0];
        end
        if (write_to(SEL_FALL_EDGE)) begin
            fall_next = CMD_WDATA[FSEF_WIDTH-1:0];
        end
        if (write_to(SEL_RISE_EDGE)) begin
            rise_next = CMD_WDATA[FSEF_WIDTH-1:0];
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            mask_reg <= FIELD_RESET;
            fall_reg <= FIELD_RESET;
            rise_reg <= FIELD_RESET;
        end else begin
            mask_reg <= mask_next;
            fall_reg <= fall_next;
            rise_reg <= rise_next;
        end
    end

    mask_write_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (CMD_WRITE && CMD_SEL == SEL_EVENT_MASK) |=> (mask_reg == 9'($past(CMD_WDATA))))
        else $error("event mask write not stored");

    // ==================================================================
    // edge filter and event latch
    assign evt.cond = cond_reg;
    assign evt.fall_sel = fall_reg;
    assign evt.rise_sel = rise_reg;
    // reading the event register empties it at the edge that ends the read, except bits with a new edge in that cycle
    assign evt.clear = CMD_READ && (CMD_SEL == SEL_EVENT);

    fsef_edge_filter fsef_edge_filter_i (
        .clk(MCLK),
        .rst_n(RST_N),
        .evt(evt.filt)
    );

    // ==================================================================
    // read port; condition and event are read-only, writes to them drop
    // an event read returns the latch as it stood before its own clear
    always_comb begin
        rdata_next = rdata_reg;
        rvalid_next = CMD_READ;
        if (CMD_READ) begin
            case (CMD_SEL)
                SEL_CONDITION: begin
                    rdata_next = widen(cond_reg);
                end
                SEL_EVENT: begin
                    rdata_next = widen(evt.event_q);
                end
                SEL_EVENT_MASK: begin
                    rdata_next = widen(mask_reg);
                end
                SEL_FALL_EDGE: begin
                    rdata_next = widen(fall_reg);
                end
                SEL_RISE_EDGE: begin
                    rdata_next = widen(rise_reg);
                end
                default: begin
                    rdata_next = WORD_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_reg <= WORD_RESET;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign RDATA = rdata_reg;
    assign RDATA_VALID = rvalid_reg;

    event_read_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (CMD_READ && CMD_SEL == SEL_EVENT)
        |=> (RDATA_VALID && RDATA == widen($past(evt.event_q))))
        else $error("event read returned the wrong value");
    upper_zero_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        RDATA_VALID |-> (RDATA[15:9] == 7'h00))
        else $error("unused upper bits read nonzero");
    read_pulse_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        !CMD_READ |=> !RDATA_VALID)
        else $error("read valid raised without a read strobe");
    rdata_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        !CMD_READ |=> $stable(RDATA))
        else $error("read data changed without a read strobe");

    // ==================================================================
    // summary bit of the status byte, one cycle behind the event latch
    always_comb begin
        summary_next = SRQ_FAULT_ENABLE && ((evt.event_q & mask_reg) != FIELD_RESET);
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            summary_reg <= 1'b0;
        end else begin
            summary_reg <= summary_next;
        end
    end

    assign FAULT_SUMMARY_BIT = summary_reg;

    summary_set_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (SRQ_FAULT_ENABLE && (evt.event_q & mask_reg) != 9'h000) |=> FAULT_SUMMARY_BIT)
        else $error("summary bit not set for a masked event");
    mask_block_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        ((evt.event_q & mask_reg) == 9'h000) |=> !FAULT_SUMMARY_BIT)
        else $error("summary bit set with all events masked");
    srq_gate_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        !SRQ_FAULT_ENABLE |=> !FAULT_SUMMARY_BIT)
        else $error("summary bit set with service request disabled");

endmodule

// ### tb/tb_fsef_fault_status.sv
// self-checking testbench for the fault status event filter
`timescale 1ns/100ps
module tb_fsef_fault_status;
    import fsef_pkg::*;

    // ==================================================================
    // stimulus and observed signals
    logic mclk = 1'b0;
    logic rst_n;
    logic srq;
    logic cmd_write;
    logic cmd_read;
    fsef_sel_t cmd_sel;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic rdata_valid;
    logic summary;
    logic [8:0] flt;
    int miscompares;
    int comparisons;

    fsef_fault_status fsef_fault_status_i (
        .MCLK(mclk),
        .RST_N(rst_n),
        .OVERVOLTAGE_FAULT(flt[8]),
        .LINE_INPUT_FAULT(flt[7]),
        .OVERCURRENT_FAULT(flt[6]),
        .COOLING_FAULT(flt[5]),
        .OUTPUT_SHORT_FAULT(flt[4]),
        .OVERTEMP_FAULT(flt[3]),
        .OVERPOWER_FAULT(flt[2]),
        .SRQ_FAULT_ENABLE(srq),
        .CMD_WRITE(cmd_write),
        .CMD_READ(cmd_read),
        .CMD_SEL(cmd_sel),
        .CMD_WDATA(wdata),
        .RDATA(rdata),
        .RDATA_VALID(rdata_valid),
        .FAULT_SUMMARY_BIT(summary)
    );

    always #10 mclk = ~mclk;

    // ==================================================================
    // compare, bus and fault tasks
    task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_flag(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic wr(input fsef_sel_t s, input logic [15:0] d);
        @(posedge mclk);
        cmd_write <= 1'b1;
        cmd_sel <= s;
        wdata <= d;
        @(posedge mclk);
        cmd_write <= 1'b0;
    endtask

    // the edge that takes the strobe also launches the answer; valid stands
    // for that one cycle only, so it is looked at just after that edge
    task automatic rd(input fsef_sel_t s, input logic [15:0] exp);
        @(posedge mclk);
        cmd_read <= 1'b1;
        cmd_sel <= s;
        @(posedge mclk);
        cmd_read <= 1'b0;
        #1;
        cmp_flag("read valid", 1'b1, rdata_valid);
        cmp_word("read data", exp, rdata);
    endtask

    // three edges cover condition, event latch and summary stages
    task automatic faults(input logic [8:0] v);
        @(posedge mclk);
        flt <= v;
        repeat (3) @(posedge mclk);
        #1;
    endtask

    // ==================================================================
    // scenarios
    task automatic reset_values();
        rd(SEL_CONDITION, 16'h0000);
        rd(SEL_EVENT, 16'h0000);
        rd(SEL_EVENT_MASK, 16'h0000);
        rd(SEL_FALL_EDGE, 16'h0000);
        rd(SEL_RISE_EDGE, 16'h0000);
        rd(fsef_sel_t'(3'h7), 16'h0000);
    endtask

    // software keeps every written value inside 0 to 511
    task automatic reg_access();
        fsef_sel_t rw[3] = '{SEL_EVENT_MASK, SEL_FALL_EDGE, SEL_RISE_EDGE};
        foreach (rw[i]) begin
            wr(rw[i], 16'h01ff);
            rd(rw[i], 16'h01ff);
            rd(fsef_sel_t'(3'h7), 16'h0000);
            wr(rw[i], 16'h00a5);
            rd(rw[i], 16'h00a5);
            wr(rw[i], 16'h0000);
            rd(rw[i], 16'h0000);
        end
        wr(SEL_CONDITION, 16'h01ff);
        rd(SEL_CONDITION, 16'h0000);
        wr(SEL_EVENT, 16'h01ff);
        rd(SEL_EVENT, 16'h0000);
    endtask

    task automatic rise_each();
        wr(SEL_RISE_EDGE, 16'h01fc);
        for (int b = 2; b <= 8; b++) begin
            faults(9'h001 << b);
            rd(SEL_CONDITION, 16'h0001 << b);
            rd(SEL_EVENT, 16'h0001 << b);
            rd(SEL_EVENT, 16'h0000);
            faults(9'h000);
            rd(SEL_EVENT, 16'h0000);
        end
    endtask

    task automatic fall_and_none();
        wr(SEL_RISE_EDGE, 16'h0000);
        wr(SEL_FALL_EDGE, 16'h01fc);
        faults(9'h1fc);
        rd(SEL_EVENT, 16'h0000);
        faults(9'h000);
        rd(SEL_EVENT, 16'h01fc);
        wr(SEL_FALL_EDGE, 16'h0000);
        faults(9'h1fc);
        faults(9'h000);
        rd(SEL_EVENT, 16'h0000);
    endtask

    task automatic summary_path();
        wr(SEL_RISE_EDGE, 16'h01fc);
        wr(SEL_EVENT_MASK, 16'h0100);
        @(posedge mclk);
        srq <= 1'b1;
        faults(9'h008);
        cmp_flag("summary masked", 1'b0, summary);
        faults(9'h108);
        cmp_flag("summary set", 1'b1, summary);
        rd(SEL_EVENT, 16'h0108);
        repeat (2) @(posedge mclk);
        #1;
        cmp_flag("summary cleared", 1'b0, summary);
        @(posedge mclk);
        srq <= 1'b0;
        faults(9'h000);
        faults(9'h100);
        cmp_flag("summary gated", 1'b0, summary);
        @(posedge mclk);
        srq <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        cmp_flag("summary enabled", 1'b1, summary);
        rd(SEL_EVENT, 16'h0100);
    endtask

    // ==================================================================
    // run control
    task automatic close_out();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // the whole run takes well under a thousand cycles
    initial begin
        #100us;
        miscompares++;
        close_out();
    end

    initial begin
        rst_n = 1'b0;
        srq = 1'b0;
        cmd_write = 1'b0;
        cmd_read = 1'b0;
        cmd_sel = SEL_CONDITION;
        wdata = 16'h0000;
        flt = 9'h000;
        miscompares = 0;
        comparisons = 0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        reset_values();
        reg_access();
        rise_each();
        fall_and_none();
        summary_path();
        close_out();
    end
endmodule
